// ---- rtl/gpio_ports.sv ----
// Six bidirectional general-purpose ports with port A wake-up
`timescale 1ns/1ps
module gpio_ports #(
  parameter int ADDR_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [gpio_pkg::PORT_W-1:0] mem_wdata,
  output logic [gpio_pkg::PORT_W-1:0] mem_rdata,
  input wire logic sleep,
  output logic wake,
  input wire logic [gpio_pkg::PORT_W-1:0] port_a_pin_in,
  output logic [gpio_pkg::PORT_W-1:0] port_a_pin_out,
  output logic [gpio_pkg::PORT_W-1:0] port_a_pin_oe,
  output logic [gpio_pkg::PORT_W-1:0] port_a_pull_on,
  input wire logic [gpio_pkg::PORT_W-1:0] port_b_pin_in,
  output logic [gpio_pkg::PORT_W-1:0] port_b_pin_out,
  output logic [gpio_pkg::PORT_W-1:0] port_b_pin_oe,
  output logic [gpio_pkg::PORT_W-1:0] port_b_pull_on,
  input wire logic [gpio_pkg::PORT_W-1:0] port_c_pin_in,
  output logic [gpio_pkg::PORT_W-1:0] port_c_pin_out,
  output logic [gpio_pkg::PORT_W-1:0] port_c_pin_oe,
  output logic [gpio_pkg::PORT_W-1:0] port_c_pull_on,
  input wire logic [gpio_pkg::PORT_W-1:0] port_d_pin_in,
  output logic [gpio_pkg::PORT_W-1:0] port_d_pin_out,
  output logic [gpio_pkg::PORT_W-1:0] port_d_pin_oe,
  output logic [gpio_pkg::PORT_W-1:0] port_d_pull_on,
  input wire logic [gpio_pkg::PORT_W-1:0] port_e_pin_in,
  output logic [gpio_pkg::PORT_W-1:0] port_e_pin_out,
  output logic [gpio_pkg::PORT_W-1:0] port_e_pin_oe,
  output logic [gpio_pkg::PORT_W-1:0] port_e_pull_on,
  input wire logic [gpio_pkg::PORT_W-1:0] port_f_pin_in,
  output logic [gpio_pkg::PORT_W-1:0] port_f_pin_out,
  output logic [gpio_pkg::PORT_W-1:0] port_f_pin_oe,
  output logic [gpio_pkg::PORT_W-1:0] port_f_pull_on
);
  import gpio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter check

  generate
    if (ADDR_W < ADDR_MIN_W) begin : g_bad_addr
      $error("gpio_ports: address too narrow for the register window");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_vec_t;

  typedef struct packed {
    port_vec_t data;
    port_vec_t dir;
    port_vec_t pull_en;
    port_vec_t oe;
    port_vec_t pull_act;
    logic [PORT_W-1:0] wake_en;
    logic [PORT_W-1:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  port_vec_t pin_in;
  port_vec_t rd_port;
  logic [NUM_PORTS-1:0][ADDR_W-1:0] addr_pull;
  logic [NUM_PORTS-1:0][ADDR_W-1:0] addr_data;
  logic [NUM_PORTS-1:0][ADDR_W-1:0] addr_dir;
  logic [ADDR_W-1:0] addr_wake;
  logic [PORT_W-1:0] rd_val;

  assign pin_in = {port_f_pin_in, port_e_pin_in, port_d_pin_in,
                   port_c_pin_in, port_b_pin_in, port_a_pin_in};
  assign addr_wake = ADDR_W'(REG_WAKE);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port addresses and read-back values

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      localparam int BASE = PORT_BASE + PORT_STRIDE * gp;
      assign addr_pull[gp] = ADDR_W'(BASE + PULL_OFS);
      assign addr_data[gp] = ADDR_W'(BASE + DATA_OFS);
      assign addr_dir[gp] = ADDR_W'(BASE + DIR_OFS);
      // Inputs read the live pin, outputs read the latch
      assign rd_port[gp] = ((s_q.dir[gp] & pin_in[gp])
                           | (~s_q.dir[gp] & s_q.data[gp]))
                           & PORT_MASK[gp];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  always_comb begin
    rd_val = '0;
    if (mem_addr == addr_wake) begin
      rd_val = s_q.wake_en;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (mem_addr == addr_pull[p]) begin
        rd_val = s_q.pull_en[p] & PORT_MASK[p];
      end
      if (mem_addr == addr_data[p]) begin
        rd_val = rd_port[p];
      end
      if (mem_addr == addr_dir[p]) begin
        rd_val = s_q.dir[p] & PORT_MASK[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    if (ce) begin
      if (mem_wr) begin
        if (mem_addr == addr_wake) begin
          s_d.wake_en = mem_wdata;
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (mem_addr == addr_pull[p]) begin
            s_d.pull_en[p] = mem_wdata & PORT_MASK[p];
          end
          // Latch holds until the next write
          if (mem_addr == addr_data[p]) begin
            s_d.data[p] = mem_wdata & PORT_MASK[p];
          end
          if (mem_addr == addr_dir[p]) begin
            s_d.dir[p] = mem_wdata & PORT_MASK[p];
          end
        end
      end
      // Sample pins at the read edge, no input latch
      if (mem_rd) begin
        s_d.rdata = rd_val;
      end
      // Pad controls follow the register values in the same edge
      for (int p = 0; p < NUM_PORTS; p++) begin
        s_d.oe[p] = ~s_d.dir[p] & PORT_MASK[p];
        s_d.pull_act[p] = s_d.pull_en[p] & s_d.dir[p] & PORT_MASK[p];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        s_q.data[p] <= DATA_RST & PORT_MASK[p];
        s_q.dir[p] <= DIR_RST & PORT_MASK[p];
        s_q.pull_en[p] <= PULL_RST;
        s_q.oe[p] <= ~(DIR_RST & PORT_MASK[p]) & PORT_MASK[p];
        s_q.pull_act[p] <= PULL_RST;
      end
      s_q.wake_en <= WAKE_RST;
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port A wake-up

  wake_if wk ();

  assign wk.ce = ce;
  assign wk.sleep = sleep;
  assign wk.enable = s_q.wake_en;
  assign wk.pins = port_a_pin_in;

  port_wake u_wake (
    .clk (clk),
    .rst_n (rst_n),
    .w (wk.unit)
  );

  assign wake = wk.wake;

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign mem_rdata = s_q.rdata;
  // Put the latch out on every pin; oe selects the pins that drive it
  assign port_a_pin_out = s_q.data[0];
  assign port_a_pin_oe = s_q.oe[0];
  assign port_a_pull_on = s_q.pull_act[0];
  assign port_b_pin_out = s_q.data[1];
  assign port_b_pin_oe = s_q.oe[1];
  assign port_b_pull_on = s_q.pull_act[1];
  assign port_c_pin_out = s_q.data[2];
  assign port_c_pin_oe = s_q.oe[2];
  assign port_c_pull_on = s_q.pull_act[2];
  assign port_d_pin_out = s_q.data[3];
  assign port_d_pin_oe = s_q.oe[3];
  assign port_d_pull_on = s_q.pull_act[3];
  assign port_e_pin_out = s_q.data[4];
  assign port_e_pin_oe = s_q.oe[4];
  assign port_e_pull_on = s_q.pull_act[4];
  assign port_f_pin_out = s_q.data[5];
  assign port_f_pin_oe = s_q.oe[5];
  assign port_f_pull_on = s_q.pull_act[5];
endmodule

// ---- rtl/gpio_pkg.sv ----
// Constants shared by the general-purpose port block
package gpio_pkg;
  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 8;
  localparam int ADDR_MIN_W = 5;
  // Implemented pins, port F down to port A
  localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PORT_MASK = {
    8'hf0, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff};
  // Register indices in the data-memory window
  localparam logic [4:0] REG_WAKE = 5'h00;
  localparam int PORT_BASE = 1;
  localparam int PORT_STRIDE = 3;
  localparam int PULL_OFS = 0;
  localparam int DATA_OFS = 1;
  localparam int DIR_OFS = 2;
  // Values after reset
  localparam logic [PORT_W-1:0] DATA_RST = 8'hff;
  localparam logic [PORT_W-1:0] DIR_RST = 8'hff;
  localparam logic [PORT_W-1:0] PULL_RST = 8'h00;
  localparam logic [PORT_W-1:0] WAKE_RST = 8'h00;
  localparam logic [PORT_W-1:0] PIN_IDLE = 8'hff;
endpackage

// ---- rtl/wake_if.sv ----
// Carrier between the port registers and the port A wake unit
`timescale 1ns/1ps
interface wake_if;
  logic ce;
  logic sleep;
  logic [gpio_pkg::PORT_W-1:0] enable;
  logic [gpio_pkg::PORT_W-1:0] pins;
  logic wake;
  modport owner (output ce, output sleep, output enable, output pins, input wake);
  modport unit (input ce, input sleep, input enable, input pins, output wake);
endinterface

// ---- rtl/port_wake.sv ----
// Port A falling-edge wake-up detector
`timescale 1ns/1ps
module port_wake (
  input wire logic clk,
  input wire logic rst_n,
  wake_if.unit w
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [PORT_W-1:0] prev;
    logic wake;
  } wake_state_t;

  wake_state_t s_q;
  wake_state_t s_d;

  assign w.wake = s_q.wake;

  always_comb begin
    s_d = s_q;
    if (w.ce) begin
      s_d.prev = w.pins;
      // High then low on an enabled pin while asleep
      s_d.wake = w.sleep & |(w.enable & s_q.prev & ~w.pins);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.prev <= PIN_IDLE;
      s_q.wake <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ---- verif/gpio_ports_chk.sv ----
// Checker for port A register and wake behaviour
`timescale 1ns/1ps
module gpio_ports_chk #(
  parameter int ADDR_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic sleep,
  input wire logic wake,
  input wire logic [7:0] port_a_pin_in,
  input wire logic [7:0] port_a_pin_out,
  input wire logic [7:0] port_a_pin_oe,
  input wire logic [7:0] port_a_pull_on
);
  import gpio_pkg::*;
  logic wd, wc, rd;
  assign wd = ce && mem_wr && mem_addr == ADDR_W'(PORT_BASE + DATA_OFS);
  assign wc = ce && mem_wr && mem_addr == ADDR_W'(PORT_BASE + DIR_OFS);
  assign rd = ce && mem_rd && mem_addr == ADDR_W'(PORT_BASE + DATA_OFS);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_DATA_WR: assert property (wd |=> port_a_pin_out == $past(mem_wdata))
    else $error("latch missed write");
  AST_DATA_HOLD: assert property (!wd |=> $stable(port_a_pin_out))
    else $error("latch changed");
  AST_DIR_WR: assert property (wc |=> port_a_pin_oe == ~$past(mem_wdata))
    else $error("drive differs from direction");
  AST_PULL_IN: assert property ((port_a_pull_on & port_a_pin_oe) == 8'h00)
    else $error("pull on output");
  AST_RD_IN: assert property (rd && !port_a_pin_oe |=>
    mem_rdata == $past(port_a_pin_in)) else $error("input read");
  AST_RD_OUT: assert property (rd && &port_a_pin_oe |=>
    mem_rdata == $past(port_a_pin_out)) else $error("output read");
  AST_RD_HOLD: assert property (!(ce && mem_rd) |=> $stable(mem_rdata))
    else $error("read data changed");
  AST_WAKE_WHY: assert property (wake |-> $past(sleep) &&
    |($past(port_a_pin_in, 2) & ~$past(port_a_pin_in))) else $error("stray wake");
  AST_WAKE_ONE: assert property (wake |=> !wake)
    else $error("wake too long");
  cover property (wake);
  cover property (rd && !port_a_pin_oe);
  cover property (wc);
endmodule
bind gpio_ports gpio_ports_chk #(.ADDR_W(ADDR_W)) chk (.clk, .rst_n, .ce, .mem_addr, .mem_wr,
  .mem_rd, .mem_wdata, .mem_rdata, .sleep, .wake, .port_a_pin_in, .port_a_pin_out,
  .port_a_pin_oe, .port_a_pull_on);

// ---- verif/pin_world.sv ----
// Switches and wiring around one port
`timescale 1ns/1ps
module pin_world (
  input wire logic clk,
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  input wire logic [7:0] pull_on,
  input wire logic [7:0] sw_en,
  input wire logic [7:0] sw_val,
  output logic [7:0] level
);
  logic [7:0] last_q = 8'h00;
  always @(posedge clk) last_q <= level;
  // Closed switch wins; a floating pin wanders
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (sw_en[i]) level[i] = sw_val[i];
      else if (drv_oe[i]) level[i] = drv_out[i];
      else if (pull_on[i]) level[i] = 1'b1;
      else level[i] = ~last_q[i];
    end
  end
endmodule

// ---- verif/tb_gpio_ports.sv ----
// Self-checking bench for the port block
`timescale 1ns/1ps
module tb_gpio_ports;
  import gpio_pkg::*;
  logic clk, rst_n, ce, mem_wr, mem_rd, sleep, wake;
  logic [4:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, rv;
  logic [5:0][7:0] po, oe, pu, pin, sw_en, sw_val;
  int bad_count = 0, tests_run = 0, cycles = 0;
  gpio_ports #(.ADDR_W(5)) uut (.clk(clk), .rst_n(rst_n), .ce(ce), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .sleep(sleep), .wake(wake),
    .port_a_pin_in(pin[0]), .port_a_pin_out(po[0]), .port_a_pin_oe(oe[0]), .port_a_pull_on(pu[0]),
    .port_b_pin_in(pin[1]), .port_b_pin_out(po[1]), .port_b_pin_oe(oe[1]), .port_b_pull_on(pu[1]),
    .port_c_pin_in(pin[2]), .port_c_pin_out(po[2]), .port_c_pin_oe(oe[2]), .port_c_pull_on(pu[2]),
    .port_d_pin_in(pin[3]), .port_d_pin_out(po[3]), .port_d_pin_oe(oe[3]), .port_d_pull_on(pu[3]),
    .port_e_pin_in(pin[4]), .port_e_pin_out(po[4]), .port_e_pin_oe(oe[4]), .port_e_pull_on(pu[4]),
    .port_f_pin_in(pin[5]), .port_f_pin_out(po[5]), .port_f_pin_oe(oe[5]), .port_f_pull_on(pu[5]));
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_pin
    pin_world pw (.clk(clk), .drv_out(po[p]), .drv_oe(oe[p]), .pull_on(pu[p]),
      .sw_en(sw_en[p]), .sw_val(sw_val[p]), .level(pin[p]));
  end
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int ra(int p, int o);
    return PORT_BASE + PORT_STRIDE * p + o;
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(int a, logic [7:0] d);
    @(negedge clk);
    mem_addr = 5'(a);
    mem_wdata = d;
    mem_wr = 1;
    @(negedge clk);
    mem_wr = 0;
  endtask
  task automatic rd(int a);
    @(negedge clk);
    mem_addr = 5'(a);
    mem_rd = 1;
    @(negedge clk);
    mem_rd = 0;
    rv = mem_rdata;
  endtask
  task automatic fall(logic [7:0] v, logic exp);
    logic seen = 0;
    @(negedge clk) sw_val[0] = 8'hff;
    @(negedge clk) sw_val[0] = v;
    repeat (3) @(negedge clk) seen |= wake;
    check("wake", {7'h00, seen}, {7'h00, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    for (int p = 0; p < NUM_PORTS; p++) begin
      check("latch", po[p], PORT_MASK[p]);
      check("oe", oe[p], 8'h00);
      check("pull", pu[p], 8'h00);
      rd(ra(p, DIR_OFS));
      check("dir", rv, PORT_MASK[p]);
      rd(ra(p, PULL_OFS));
      check("pull reg", rv, 8'h00);
      rd(ra(p, DATA_OFS));
      check("in read", rv, 8'h5a & PORT_MASK[p]);
    end
    sw_val[1] = 8'hc3;
    rd(ra(1, DATA_OFS));
    check("live read", rv, 8'h03);
    rd(REG_WAKE);
    check("wake reg", rv, 8'h00);
    rd(5'h1f);
    check("unmapped", rv, 8'h00);
  endtask
  task automatic test_output;
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr(ra(p, DIR_OFS), 8'h00);
      check("oe", oe[p], PORT_MASK[p]);
      check("high", po[p], PORT_MASK[p]);
      wr(ra(p, DATA_OFS), 8'ha5);
      ce = 0;
      wr(ra(p, DATA_OFS), 8'h00);
      ce = 1;
      check("latch", po[p], 8'ha5 & PORT_MASK[p]);
      rd(ra(p, DATA_OFS));
      check("out read", rv, 8'ha5 & PORT_MASK[p]);
      wr(ra(p, PULL_OFS), 8'hff);
      check("pull out", pu[p], 8'h00);
      wr(ra(p, DIR_OFS), 8'hff);
      check("pull in", pu[p], PORT_MASK[p]);
      sw_en[p] = 8'h00;
      rd(ra(p, DATA_OFS));
      check("pulled", rv, PORT_MASK[p]);
      sw_en[p] = 8'hff;
    end
  endtask
  task automatic test_wake;
    wr(REG_WAKE, 8'h01);
    rd(REG_WAKE);
    check("wake reg", rv, 8'h01);
    sleep = 1;
    fall(8'hfe, 1'b1);
    fall(8'hfd, 1'b0);
    sleep = 0;
    fall(8'hfe, 1'b0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    rst_n = 0;
    ce = 1;
    {mem_wr, mem_rd, sleep, mem_addr, mem_wdata} = '0;
    sw_en = '1;
    sw_val = {6{8'h5a}};
    repeat (4) @(negedge clk);
    rst_n = 1;
    test_reset();
    test_output();
    test_wake();
    complete_run();
  end
endmodule
